// file: verilog/sis_pkg.sv
// package: constants for the scsi interrupt source block
package sis_pkg;
  // register addresses
  localparam logic [2:0] A_DATA   = 3'h0;
  localparam logic [2:0] A_ICMD   = 3'h1;
  localparam logic [2:0] A_MODE   = 3'h2;
  localparam logic [2:0] A_TCMD   = 3'h3;
  localparam logic [2:0] A_LINES  = 3'h4;
  localparam logic [2:0] A_SELID  = 3'h4;
  localparam logic [2:0] A_FLAGS  = 3'h5;
  localparam logic [2:0] A_CLEAR  = 3'h7;
  // initiator command bits
  localparam int ICMD_RST  = 7;
  localparam int ICMD_TEST = 6;
  localparam int ICMD_ACK  = 4;
  localparam int ICMD_BSY  = 3;
  localparam int ICMD_SEL  = 2;
  localparam int ICMD_ATN  = 1;
  localparam int ICMD_DBUS = 0;
  // mode control bits
  localparam int MODE_TGT  = 6;
  localparam int MODE_PAR  = 5;
  localparam int MODE_PARI = 4;
  localparam int MODE_EOD  = 3;
  localparam int MODE_MON  = 2;
  localparam int MODE_DMA  = 1;
  localparam logic [7:0] REG_RST = 8'h00;
  // timing
  localparam int CNT_W     = 8;
  localparam int CLK_NS    = 20;
  localparam int SETTLE_NS = 400;
  localparam int EOP_NS    = 40;
  localparam logic [CNT_W-1:0] SETTLE_CYC =
    CNT_W'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] EOP_CYC =
    CNT_W'((EOP_NS + CLK_NS - 1) / CLK_NS);
  localparam int SYNC_W = 34;
endpackage

// file: verilog/sis_core.sv
// scsi interrupt sources, status latches and register port
`timescale 1ns/1ns
module sis_core
(
  input  wire logic       CLK_SYS,
  input  wire logic       RESET_N,
  input  wire logic       CHIP_SELECT_N,
  input  wire logic       READ_STROBE_N,
  input  wire logic       WRITE_STROBE_N,
  input  wire logic [2:0] REGISTER_ADDRESS_LINES,
  input  wire logic [7:0] HOST_DATA_IN,
  output logic      [7:0] HOST_DATA_OUT,
  output logic            HOST_DATA_OE,
  input  wire logic       DMA_ACKNOWLEDGE_N,
  input  wire logic       END_OF_PROCESS_INPUT_N,
  output logic            IRQ,
  output logic            IRQ_OE,
  input  wire logic [7:0] SCSI_DATA_N_IN,
  input  wire logic       SCSI_DBP_N_IN,
  input  wire logic       SCSI_RST_N_IN,
  input  wire logic       SCSI_BSY_N_IN,
  input  wire logic       SCSI_SEL_N_IN,
  input  wire logic       SCSI_REQ_N_IN,
  input  wire logic       SCSI_ACK_N_IN,
  input  wire logic       SCSI_MSG_N_IN,
  input  wire logic       SCSI_CD_N_IN,
  input  wire logic       SCSI_IO_N_IN,
  input  wire logic       SCSI_ATN_N_IN,
  output logic      [7:0] SCSI_DATA_N_OUT,
  output logic            SCSI_DATA_OE,
  output logic            SCSI_RST_OE,
  output logic            SCSI_BSY_OE,
  output logic            SCSI_SEL_OE,
  output logic            SCSI_ACK_OE,
  output logic            SCSI_ATN_OE
);
  import sis_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, inverted to active high before the first stage
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] raw;
  logic [7:0]        bus_data;
  logic              dbp;
  logic              rst_l;
  logic              bsy;
  logic              sel;
  logic              req;
  logic              ack;
  logic              msg;
  logic              cd;
  logic              io;
  logic              atn;
  logic              cs;
  logic              rd;
  logic              wr;
  logic              dma_acknowledge;
  logic              eop;
  logic [2:0]        addr;
  logic [7:0]        din;

  assign raw = {~SCSI_DATA_N_IN, ~SCSI_DBP_N_IN, ~SCSI_RST_N_IN,
                ~SCSI_BSY_N_IN, ~SCSI_SEL_N_IN, ~SCSI_REQ_N_IN,
                ~SCSI_ACK_N_IN, ~SCSI_MSG_N_IN, ~SCSI_CD_N_IN,
                ~SCSI_IO_N_IN, ~SCSI_ATN_N_IN, ~CHIP_SELECT_N,
                ~READ_STROBE_N, ~WRITE_STROBE_N, ~DMA_ACKNOWLEDGE_N,
                ~END_OF_PROCESS_INPUT_N, REGISTER_ADDRESS_LINES,
                HOST_DATA_IN};

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  assign {bus_data, dbp, rst_l, bsy, sel, req, ack, msg, cd, io, atn,
          cs, rd, wr, dma_acknowledge, eop, addr, din} = sync2;

  ////////////////////////////////////////////////////////////////////////////
  // host access strobes, one pulse per access
  logic       rd_acc;
  logic       wr_acc;
  logic       rd_prev;
  logic       wr_prev;
  logic       rd_pulse;
  logic       wr_pulse;
  logic       clr_pulse;

  assign rd_acc    = cs & rd;
  assign wr_acc    = cs & wr;
  assign rd_pulse  = rd_acc & ~rd_prev;
  assign wr_pulse  = wr_acc & ~wr_prev;
  assign clr_pulse = rd_pulse & (addr == A_CLEAR);

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end
    else
    begin
      rd_prev <= rd_acc;
      wr_prev <= wr_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  logic [7:0] init_cmd;
  logic [7:0] mode_control;
  logic [2:0] target_phase;
  logic [7:0] own_identity_match;
  logic [7:0] out_data;
  logic       busy_evt;

  // busy error wins over a write in the same cycle
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      init_cmd <= REG_RST;
    else if (busy_evt)
      init_cmd[5:0] <= 6'h00;
    else if (wr_pulse && addr == A_ICMD)
      init_cmd <= {din[7:6], 1'b0, din[4:0]};
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      mode_control <= REG_RST;
    else if (busy_evt)
      mode_control[MODE_DMA] <= 1'b0;
    else if (wr_pulse && addr == A_MODE)
      mode_control <= din;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      target_phase       <= 3'h0;
      own_identity_match <= REG_RST;
      out_data           <= REG_RST;
    end
    else if (wr_pulse)
    begin
      if (addr == A_TCMD)
        target_phase <= din[2:0];
      if (addr == A_SELID)
        own_identity_match <= din;
      if (addr == A_DATA)
        out_data <= din;
    end
  end

  logic dma_en;
  assign dma_en = mode_control[MODE_DMA];

  ////////////////////////////////////////////////////////////////////////////
  // busy monitor: counts cycles with busy released, saturating
  logic [CNT_W-1:0] bsy_cnt;
  logic             bus_free;

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      bsy_cnt <= '0;
    else if (bsy)
      bsy_cnt <= '0;
    else if (bsy_cnt != SETTLE_CYC)
      bsy_cnt <= bsy_cnt + 1'b1;
  end

  assign bus_free = (bsy_cnt == SETTLE_CYC);
  // fires once, on the cycle the settle delay completes
  assign busy_evt = mode_control[MODE_MON] & ~bsy
                  & (bsy_cnt == SETTLE_CYC - 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // condition detectors; each interrupt cause fires on its rising edge
  logic       phase_match;
  logic       req_seen;
  logic       sel_cond;
  logic       mis_cond;
  logic       chk_cond;
  logic       par_bad;
  logic [3:0] cond_prev;
  logic       rst_evt;
  logic       sel_evt;
  logic       mis_evt;
  logic       chk_evt;
  logic       par_evt;

  assign phase_match = ({msg, cd, io} == target_phase);
  assign req_seen    = req & phase_match;
  assign sel_cond    = sel & |(bus_data & own_identity_match)
                     & bus_free;
  assign mis_cond    = dma_en & req & ~phase_match;
  // programmed read of data, or dma receive strobe
  assign chk_cond    = (rd_acc & (addr == A_DATA))
                     | (dma_en & (mode_control[MODE_TGT] ? ack
                                                          : req_seen));
  assign par_bad     = ~(^{bus_data, dbp});
  assign rst_evt     = rst_l & ~cond_prev[0];
  assign sel_evt     = sel_cond & ~cond_prev[1];
  assign mis_evt     = mis_cond & ~cond_prev[2];
  assign chk_evt     = chk_cond & ~cond_prev[3];
  assign par_evt     = chk_evt & par_bad & mode_control[MODE_PAR];

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      cond_prev <= 4'h0;
    else
      cond_prev <= {chk_cond, mis_cond, sel_cond, rst_l};
  end

  ////////////////////////////////////////////////////////////////////////////
  // end of process qualification
  logic             eop_ok;
  logic [CNT_W-1:0] eop_cnt;
  logic             eop_evt;

  assign eop_ok  = eop & dma_acknowledge & (rd | wr);
  assign eop_evt = eop_ok & (eop_cnt == EOP_CYC - 1'b1);

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      eop_cnt <= '0;
    else if (!eop_ok)
      eop_cnt <= '0;
    else if (eop_cnt != EOP_CYC)
      eop_cnt <= eop_cnt + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // status latches; a setting event beats a clear read in the same cycle, but dma off beats end of process
  logic par_err;
  logic busy_err;
  logic end_dma;
  logic irq_latch;
  logic any_evt;

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      par_err <= 1'b0;
    else if (par_evt)
      par_err <= 1'b1;
    else if (clr_pulse)
      par_err <= 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      busy_err <= 1'b0;
    else if (busy_evt)
      busy_err <= 1'b1;
    else if (clr_pulse)
      busy_err <= 1'b0;
  end

  // the latch only lives while dma is enabled
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      end_dma <= 1'b0;
    else if (!dma_en)
      end_dma <= 1'b0;
    else if (eop_evt)
      end_dma <= 1'b1;
  end

  assign any_evt = rst_evt
                 | sel_evt
                 | busy_evt
                 | mis_evt
                 | (par_evt & mode_control[MODE_PARI])
                 | (eop_evt & dma_en & mode_control[MODE_EOD]);

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      irq_latch <= 1'b0;
    else if (any_evt)
      irq_latch <= 1'b1;
    else if (clr_pulse)
      irq_latch <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all registered; busy error drops every bus driver
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      IRQ             <= 1'b0;
      IRQ_OE          <= 1'b0;
      SCSI_DATA_N_OUT <= 8'hff;
      SCSI_DATA_OE    <= 1'b0;
      SCSI_RST_OE     <= 1'b0;
      SCSI_BSY_OE     <= 1'b0;
      SCSI_SEL_OE     <= 1'b0;
      SCSI_ACK_OE     <= 1'b0;
      SCSI_ATN_OE     <= 1'b0;
    end
    else
    begin
      IRQ             <= irq_latch;
      IRQ_OE          <= ~init_cmd[ICMD_TEST];
      SCSI_DATA_N_OUT <= ~out_data;
      SCSI_DATA_OE    <= init_cmd[ICMD_DBUS] & phase_match
                       & ~busy_err;
      SCSI_RST_OE     <= init_cmd[ICMD_RST] & ~busy_err;
      SCSI_BSY_OE     <= init_cmd[ICMD_BSY] & ~busy_err;
      SCSI_SEL_OE     <= init_cmd[ICMD_SEL] & ~busy_err;
      SCSI_ACK_OE     <= init_cmd[ICMD_ACK] & ~busy_err;
      SCSI_ATN_OE     <= init_cmd[ICMD_ATN] & ~busy_err;
    end
  end

  // read data is one cycle behind the synchronised strobe
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      HOST_DATA_OUT <= 8'h00;
      HOST_DATA_OE  <= 1'b0;
    end
    else
    begin
      HOST_DATA_OE <= rd_acc;
      case (addr)
        A_DATA:  HOST_DATA_OUT <= bus_data;
        A_ICMD:  HOST_DATA_OUT <= {init_cmd[7:5], init_cmd[4:0]};
        A_MODE:  HOST_DATA_OUT <= mode_control;
        A_TCMD:  HOST_DATA_OUT <= {5'h00, target_phase};
        A_LINES: HOST_DATA_OUT <= {rst_l, bsy, req, msg, cd, io, sel,
                                   dbp};
        A_FLAGS: HOST_DATA_OUT <= {end_dma, 1'b0, par_err, irq_latch,
                                   phase_match, busy_err, atn,
                                   ack};
        default: HOST_DATA_OUT <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  a_rst_irq_set:
    assert property (rst_evt |=> irq_latch ##1 IRQ)
    else $error("bus reset did not raise the interrupt");

  a_sel_blocked:
    assert property (own_identity_match == 8'h00 |-> !sel_evt)
    else $error("selection interrupt with empty identity match");

  a_busy_settle:
    assert property ($rose(busy_err) |->
                     $past(bsy_cnt) == SETTLE_CYC - 1'b1 && !$past(bsy))
    else $error("busy error before the settle delay");

  a_busy_monitor:
    assert property ($rose(busy_err) |-> $past(mode_control[MODE_MON]))
    else $error("busy error while monitor is off");

  a_busy_disable:
    assert property ($rose(busy_err) |->
                     !dma_en && init_cmd[5:0] == 6'h00
                     ##1 !SCSI_BSY_OE && !SCSI_DATA_OE)
    else $error("busy error left the bus driven");

  a_phase_irq:
    assert property (mis_evt |=> irq_latch)
    else $error("phase mismatch did not raise the interrupt");

  a_phase_drive:
    assert property (!phase_match |=> !SCSI_DATA_OE)
    else $error("data driven during phase mismatch");

  a_parity_gate:
    assert property ($rose(par_err) |-> $past(mode_control[MODE_PAR]))
    else $error("parity error set while checking is off");

  a_clear_read:
    assert property (clr_pulse && !any_evt |=> !irq_latch ##1 !IRQ)
    else $error("clear read left the interrupt set");

  a_eod_drop:
    assert property (!dma_en |=> !end_dma)
    else $error("end of dma latch held with dma off");

  a_eop_valid:
    assert property ($rose(end_dma) |-> $past(eop_ok, 1) && $past(eop_ok, 2))
    else $error("end of dma without a held end of process");

endmodule // sis_core

// file: tb/sis_bus_peer.sv
// other scsi devices on the bus, resolving the open-drain lines
`timescale 1ns/1ns
module sis_bus_peer
(
  input  wire logic       p_rst,
  input  wire logic       p_bsy,
  input  wire logic       p_sel,
  input  wire logic       p_req,
  input  wire logic       p_msg,
  input  wire logic       p_cd,
  input  wire logic       p_io,
  input  wire logic       p_den,
  input  wire logic [7:0] p_data,
  input  wire logic       p_par,
  input  wire logic [7:0] dout_n,
  input  wire logic       data_oe,
  input  wire logic       rst_oe,
  input  wire logic       bsy_oe,
  input  wire logic       sel_oe,
  input  wire logic       ack_oe,
  input  wire logic       atn_oe,
  output logic      [7:0] data_n,
  output logic            dbp_n,
  output logic            rst_n,
  output logic            bsy_n,
  output logic            sel_n,
  output logic            req_n,
  output logic            ack_n,
  output logic            msg_n,
  output logic            cd_n,
  output logic            io_n,
  output logic            atn_n
);
  ////////////////////////////////////////////////////////////////////////////
  // terminated bus: a released line is pulled high, so it reads inactive
  assign rst_n  = ~(p_rst | rst_oe);
  assign bsy_n  = ~(p_bsy | bsy_oe);
  assign sel_n  = ~(p_sel | sel_oe);
  assign req_n  = ~p_req;
  assign ack_n  = ~ack_oe;
  assign atn_n  = ~atn_oe;
  assign msg_n  = ~p_msg;
  assign cd_n   = ~p_cd;
  assign io_n   = ~p_io;
  // wired-and of both drivers on the data lines
  assign data_n = (p_den ? ~p_data : 8'hff) & (data_oe ? dout_n : 8'hff);
  assign dbp_n  = p_den ? ~p_par : 1'b1;
endmodule // sis_bus_peer

// file: tb/tb.sv
// self-checking bench for the scsi interrupt source block
`timescale 1ns/1ns
module tb;
  import sis_pkg::*;
  logic clk_sys, reset_n, cs_n, rd_n, wr_n, dma_acknowledge_n, eop_n;
  logic [2:0] addr;
  logic [7:0] din, dout, q, p_data, dn_out, dn_in;
  logic doe, irq, irq_oe, d_oe, r_oe, b_oe, s_oe, a_oe, t_oe;
  logic p_rst, p_bsy, p_sel, p_req, p_msg, p_cd, p_io, p_den, p_par;
  logic dbp_n, rst_n, bsy_n, sel_n, req_n, ack_n, msg_n, cd_n, io_n, atn_n;
  logic [2:0] k, t, d;
  logic io;
  int n_errors, comparisons;
  logic [31:0] rng;
  ////////////////////////////////////////////////////////////////////////////
  sis_core sis_core_i (.CLK_SYS(clk_sys), .RESET_N(reset_n),
    .CHIP_SELECT_N(cs_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
    .REGISTER_ADDRESS_LINES(addr), .HOST_DATA_IN(din),
    .HOST_DATA_OUT(dout), .HOST_DATA_OE(doe), .DMA_ACKNOWLEDGE_N(dma_acknowledge_n),
    .END_OF_PROCESS_INPUT_N(eop_n), .IRQ(irq), .IRQ_OE(irq_oe),
    .SCSI_DATA_N_IN(dn_in), .SCSI_DBP_N_IN(dbp_n), .SCSI_RST_N_IN(rst_n),
    .SCSI_BSY_N_IN(bsy_n), .SCSI_SEL_N_IN(sel_n), .SCSI_REQ_N_IN(req_n),
    .SCSI_ACK_N_IN(ack_n), .SCSI_MSG_N_IN(msg_n), .SCSI_CD_N_IN(cd_n),
    .SCSI_IO_N_IN(io_n), .SCSI_ATN_N_IN(atn_n), .SCSI_DATA_N_OUT(dn_out),
    .SCSI_DATA_OE(d_oe), .SCSI_RST_OE(r_oe), .SCSI_BSY_OE(b_oe),
    .SCSI_SEL_OE(s_oe), .SCSI_ACK_OE(a_oe), .SCSI_ATN_OE(t_oe));
  sis_bus_peer sis_bus_peer_i (.p_rst(p_rst), .p_bsy(p_bsy), .p_sel(p_sel),
    .p_req(p_req), .p_msg(p_msg), .p_cd(p_cd), .p_io(p_io), .p_den(p_den),
    .p_data(p_data), .p_par(p_par), .dout_n(dn_out), .data_oe(d_oe),
    .rst_oe(r_oe), .bsy_oe(b_oe), .sel_oe(s_oe), .ack_oe(a_oe),
    .atn_oe(t_oe), .data_n(dn_in), .dbp_n(dbp_n), .rst_n(rst_n),
    .bsy_n(bsy_n), .sel_n(sel_n), .req_n(req_n), .ack_n(ack_n),
    .msg_n(msg_n), .cd_n(cd_n), .io_n(io_n), .atn_n(atn_n));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // strobes held 5 cycles, released 4: above the 3-cycle sync spacing
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    addr = a;
    din = v;
    cs_n = 1'b0;
    wr_n = 1'b0;
    cyc(5);
    cs_n = 1'b1;
    wr_n = 1'b1;
    cyc(4);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    addr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    cyc(5);
    v = doe ? dout : 8'hxx;
    cs_n = 1'b1;
    rd_n = 1'b1;
    cyc(4);
  endtask
  // bounded wait for the request line to rise
  task automatic wirq();
    for (int i = 0; i < 60 && irq !== 1'b1; i++)
      cyc(1);
    chk("irq_rise", {7'h0, irq}, 8'h01);
    if (irq !== 1'b1)
      finish_test();
  endtask
  task automatic noirq(input string nm);
    cyc(40);
    chk(nm, {7'h0, irq}, 8'h00);
  endtask
  task automatic eop(input logic dk);
    eop_n = 1'b0;
    dma_acknowledge_n = ~dk;
    rd_n = 1'b0;
    cyc(6);
    eop_n = 1'b1;
    dma_acknowledge_n = 1'b1;
    rd_n = 1'b1;
    cyc(4);
  endtask
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    $display("Error watchdog expected end seen hang");
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rng = 32'd39224;
    {cs_n, rd_n, wr_n, dma_acknowledge_n, eop_n} = 5'h1f;
    {p_rst, p_bsy, p_sel, p_req, p_msg, p_cd, p_io, p_den, p_par} = 9'h0;
    addr = 3'h0;
    din = 8'h00;
    p_data = 8'h00;
    n_errors = 0;
    comparisons = 0;
    reset_n = 1'b0;
    cyc(10);
    reset_n = 1'b1;
    cyc(4);
    rd(A_MODE, q); chk("mode_rst", q, REG_RST);
    rd(A_FLAGS, q); chk("flags_rst", q, 8'h08);
    noirq("irq_idle_nomon");
    wr(A_ICMD, 8'h40); chk("irq_oe_test", {7'h0, irq_oe}, 8'h00);
    wr(A_ICMD, 8'h00); chk("irq_oe_run", {7'h0, irq_oe}, 8'h01);
    $display("done reset and test mode");
    p_rst = 1'b1;
    cyc(6);
    rd(A_LINES, q); chk("rst_live", q & 8'h80, 8'h80);
    p_rst = 1'b0;
    wirq();
    rd(A_FLAGS, q); chk("rst_flags", q, 8'h18);
    rd(A_CLEAR, q); chk("irq_clr", {7'h0, irq}, 8'h00);
    wr(A_ICMD, 8'h80); chk("rst_drive", {7'h0, r_oe}, 8'h01);
    wirq();
    wr(A_ICMD, 8'h00);
    rd(A_CLEAR, q);
    $display("done bus reset");
    for (int c = 0; c < 3; c++)
    begin
      k = xs() % 8;
      io = xs() % 2;
      wr(A_SELID, c == 2 ? 8'h00 : 8'h01 << k);
      p_data = 8'h01 << (c == 1 ? k + 3'h1 : k);
      p_den = 1'b1;
      p_io = io;
      p_sel = 1'b1;
      if (c == 0)
      begin
        wirq();
        rd(A_LINES, q); chk("sel_lines", q & 8'h06, {5'h0, io, 2'h2});
      end
      else
        noirq("sel_masked");
      {p_sel, p_den, p_io} = 3'h0;
      rd(A_CLEAR, q);
    end
    $display("done selection");
    t = xs() % 8;
    d = xs() % 7 + 1;
    wr(A_TCMD, {5'h0, t});
    {p_msg, p_cd, p_io} = t ^ d;
    cyc(6);
    rd(A_FLAGS, q); chk("phase_miss", q & 8'h08, 8'h00);
    p_req = 1'b1;
    noirq("phase_nodma");
    wr(A_ICMD, 8'h01); chk("drv_off", {7'h0, d_oe}, 8'h00);
    wr(A_MODE, 8'h02);
    wirq();
    {p_msg, p_cd, p_io} = t;
    cyc(8);
    chk("drv_on", {7'h0, d_oe}, 8'h01);
    rd(A_FLAGS, q); chk("phase_hit", q & 8'h08, 8'h08);
    wr(A_ICMD, 8'h00);
    wr(A_MODE, 8'h00);
    {p_req, p_msg, p_cd, p_io} = 4'h0;
    wr(A_TCMD, 8'h00);
    rd(A_CLEAR, q);
    $display("done phase");
    p_data = xs();
    p_den = 1'b1;
    p_par = ~^p_data;
    wr(A_MODE, 8'h30);
    rd(A_DATA, q); chk("bus_data", q, p_data);
    noirq("parity_good");
    p_par = ^p_data;
    rd(A_DATA, q);
    wirq();
    rd(A_FLAGS, q); chk("par_set", q & 8'h30, 8'h30);
    rd(A_CLEAR, q);
    rd(A_FLAGS, q); chk("par_clr", q & 8'h30, 8'h00);
    wr(A_MODE, 8'h10);
    rd(A_DATA, q);
    noirq("par_off");
    rd(A_FLAGS, q); chk("par_nolatch", q & 8'h20, 8'h00);
    // target receive: our own ack edge triggers the dma parity check
    wr(A_MODE, 8'h62);
    wr(A_ICMD, 8'h10);
    rd(A_FLAGS, q); chk("par_tgt_ack", q & 8'h20, 8'h20);
    wr(A_ICMD, 8'h00);
    wr(A_MODE, 8'h00);
    rd(A_CLEAR, q);
    p_den = 1'b0;
    $display("done parity");
    wr(A_MODE, 8'h0a);
    eop(1'b0);
    noirq("eop_nodack");
    eop(1'b1);
    wirq();
    rd(A_FLAGS, q); chk("eod_set", q & 8'h80, 8'h80);
    rd(A_CLEAR, q);
    wr(A_MODE, 8'h00);
    wr(A_MODE, 8'h02);
    eop(1'b1);
    noirq("eod_masked");
    rd(A_FLAGS, q); chk("eod_latch", q & 8'h80, 8'h80);
    wr(A_MODE, 8'h00);
    rd(A_FLAGS, q); chk("eod_clr", q & 8'h80, 8'h00);
    $display("done end of dma");
    p_bsy = 1'b1;
    cyc(30);
    p_bsy = 1'b0;
    noirq("busy_nomon");
    p_bsy = 1'b1;
    wr(A_MODE, 8'h06);
    wr(A_ICMD, 8'h17);
    chk("drv_busy", {3'h0, a_oe, b_oe, s_oe, t_oe, d_oe}, 8'h17);
    p_bsy = 1'b0;
    cyc(10); chk("busy_early", {7'h0, irq}, 8'h00);
    wirq();
    rd(A_FLAGS, q); chk("busy_flags", q, 8'h1c);
    rd(A_MODE, q); chk("busy_mode", q, 8'h04);
    rd(A_ICMD, q); chk("busy_icmd", q, 8'h00);
    chk("busy_drv", {2'h0, r_oe, a_oe, b_oe, s_oe, t_oe, d_oe}, 8'h00);
    rd(A_CLEAR, q);
    rd(A_FLAGS, q); chk("busy_clr", q, 8'h08);
    wr(A_MODE, 8'h00);
    $display("done loss of busy");
    finish_test();
  end
endmodule // tb
